// ---- inc/hsb_pkg.sv ----
package hsb_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned CMD_DIR_POS  = 7;
  localparam int unsigned CMD_INC_POS  = 6;
  localparam int unsigned CLK_FREQ_HZ  = 20000000;
  localparam int unsigned SCK_HALF_DEF = 4;
  localparam int unsigned STB_HALF_DEF = 4;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [2:0]  BIT_CNT_RST  = 3'h0;
  localparam logic [31:0] REG_CTRL     = 32'h0000_0000;
  localparam logic [31:0] REG_CMD      = 32'h0000_0004;
  localparam logic [31:0] REG_WDATA    = 32'h0000_0008;
  localparam logic [31:0] REG_RDATA    = 32'h0000_000c;
  localparam logic [31:0] REG_STATUS   = 32'h0000_0010;
  localparam logic [31:0] REG_BYPASS   = 32'h0000_0014;
endpackage : hsb_pkg

// ---- inc/hsb_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface hsb_if;
  logic sck;
  logic mosi;
  logic miso;
  logic ss_n;
  logic irq_strobe;
  logic bypass_bit_data_dev;
  logic bypass_bit_valid_dev;
  logic bypass_bit_data_host;
  logic bypass_bit_valid_host;
  logic bypass_dev_oe;
  logic bypass_host_oe;
  modport device (input sck, input mosi, input ss_n, output miso, output irq_strobe,
                  output bypass_bit_data_dev, output bypass_bit_valid_dev, output bypass_dev_oe,
                  input bypass_bit_data_host, input bypass_bit_valid_host, input bypass_host_oe);
  modport host (output sck, output mosi, output ss_n, input miso, input irq_strobe,
                input bypass_bit_data_dev, input bypass_bit_valid_dev, input bypass_dev_oe,
                output bypass_bit_data_host, output bypass_bit_valid_host, output bypass_host_oe);
endinterface : hsb_if
`default_nettype wire

// ---- logic/hsb_device.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - four wires: mosi, miso, sck, ss
// - host clocks; shift in mosi, out miso
// - host lowers select before transfer
// - first byte command, rest data
// - select held low whole transaction
// - bit7 zero read, one write
// - bit6 set increments address per byte
// - six bit address, eight bit data
// - burst length unlimited
// - select high ends transaction
// - bypass path carries payload bits only
// - receive: bit valid after strobe fall
// - transmit: capture bit on strobe fall
// - host samples bypass on strobe rise
module hsb_device
  import hsb_pkg::*;
#(
  parameter int unsigned STB_HALF = STB_HALF_DEF
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // link
  hsb_if.device                  lnk,
  // register side
  output logic                   reg_we,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [DATA_W-1:0]      reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata,
  // bypass payload side
  input  wire logic              byp_enable,
  input  wire logic              byp_tx_mode,
  input  wire logic              byp_rx_bit,
  input  wire logic              byp_rx_valid,
  output logic                   byp_tx_bit,
  output logic                   byp_tx_valid,
  output logic                   byp_tx_take
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [2:0] s1_q, s2_q, s1_d;
  logic       sck_old_q;
  logic       h1_q, h2_q, h1_d;
  always_comb begin
    s1_d = {lnk.sck, lnk.mosi, lnk.ss_n};
    h1_d = lnk.bypass_bit_data_host;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q      <= 3'h1;
      s2_q      <= 3'h1;
      sck_old_q <= 1'b0;
      h1_q      <= 1'b0;
      h2_q      <= 1'b0;
    end else begin
      s1_q      <= s1_d;
      s2_q      <= s1_q;
      sck_old_q <= s2_q[2];
      h1_q      <= h1_d;
      h2_q      <= h1_q;
    end
  end
  logic v1_q, v2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
    end else begin
      v1_q <= lnk.bypass_bit_valid_host;
      v2_q <= v1_q;
    end
  end
  logic sck_s, mosi_s, ss_s, sck_rise, sck_fall;
  always_comb begin
    sck_s    = s2_q[2];
    mosi_s   = s2_q[1];
    ss_s     = s2_q[0];
    sck_rise = sck_s & ~sck_old_q;
    sck_fall = ~sck_s & sck_old_q;
  end
  ////////////////////////////////////////////////////////////////////////////
  // spi slave
  logic [2:0]        cnt_q, cnt_d;
  logic [7:0]        sh_q, sh_d, tx_q, tx_d;
  logic              cmd_q, cmd_d, dir_q, dir_d, inc_q, inc_d, wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0]        wd_q, wd_d;
  logic              miso_q, miso_d, rd_q, rd_d;
  logic [7:0]        nb;
  always_comb begin
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    tx_d   = tx_q;
    cmd_d  = cmd_q;
    dir_d  = dir_q;
    inc_d  = inc_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    wr_d   = 1'b0;
    rd_d   = 1'b0;
    miso_d = miso_q;
    nb     = {sh_q[6:0], mosi_s};
    if (ss_s) begin
      cnt_d  = BIT_CNT_RST;
      cmd_d  = 1'b1;
      miso_d = 1'b0;
    end else begin
      if (rd_q) begin
        tx_d = reg_rdata;
      end
      if (wr_q && inc_q) begin
        addr_d = addr_q + 6'h01;
      end
      if (sck_rise) begin
        sh_d  = nb;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          if (cmd_q) begin
            cmd_d  = 1'b0;
            dir_d  = nb[CMD_DIR_POS];
            inc_d  = nb[CMD_INC_POS];
            addr_d = nb[ADDR_W-1:0];
            rd_d   = ~nb[CMD_DIR_POS];
          end else begin
            if (dir_q) begin
              wd_d = nb;
              wr_d = 1'b1;
            end else begin
              rd_d = 1'b1;
            end
            if (inc_q && !dir_q) begin
              addr_d = addr_q + 6'h01;
            end
          end
        end
      end
      if (sck_fall) begin
        if (!cmd_q && !dir_q) begin
          miso_d = tx_q[3'h7 - cnt_q];
        end else begin
          miso_d = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= BIT_CNT_RST;
      sh_q   <= BYTE_RESET;
      tx_q   <= BYTE_RESET;
      cmd_q  <= 1'b1;
      dir_q  <= 1'b0;
      inc_q  <= 1'b0;
      addr_q <= '0;
      wd_q   <= BYTE_RESET;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      tx_q   <= tx_d;
      cmd_q  <= cmd_d;
      dir_q  <= dir_d;
      inc_q  <= inc_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      miso_q <= miso_d;
    end
  end
  assign lnk.miso  = miso_q;
  assign reg_we    = wr_q;
  assign reg_addr  = addr_q;
  assign reg_wdata = wd_q;
  ////////////////////////////////////////////////////////////////////////////
  // bypass strobe
  logic [7:0] div_q, div_d;
  logic       stb_q, stb_d, bd_q, bd_d, bv_q, bv_d, tb_q, tb_d, tv_q, tv_d, tk_q, tk_d;
  always_comb begin
    div_d = div_q;
    stb_d = stb_q;
    bd_d  = bd_q;
    bv_d  = bv_q;
    tb_d  = tb_q;
    tv_d  = tv_q;
    tk_d  = 1'b0;
    if (!byp_enable) begin
      div_d = 8'h00;
      stb_d = 1'b1;
      bv_d  = 1'b0;
    end else if (div_q == 8'(STB_HALF - 1)) begin
      div_d = 8'h00;
      stb_d = ~stb_q;
      if (stb_q) begin
        if (byp_tx_mode) begin
          tb_d = h2_q;
          tv_d = v2_q;
          tk_d = 1'b1;
        end else begin
          bd_d = byp_rx_bit;
          bv_d = byp_rx_valid;
        end
      end
    end else begin
      div_d = div_q + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      stb_q <= 1'b1;
      bd_q  <= 1'b0;
      bv_q  <= 1'b0;
      tb_q  <= 1'b0;
      tv_q  <= 1'b0;
      tk_q  <= 1'b0;
    end else begin
      div_q <= div_d;
      stb_q <= stb_d;
      bd_q  <= bd_d;
      bv_q  <= bv_d;
      tb_q  <= tb_d;
      tv_q  <= tv_d;
      tk_q  <= tk_d;
    end
  end
  assign lnk.irq_strobe           = stb_q;
  assign lnk.bypass_bit_data_dev  = bd_q;
  assign lnk.bypass_bit_valid_dev = bv_q;
  assign lnk.bypass_dev_oe        = byp_enable & ~byp_tx_mode;
  assign byp_tx_bit               = tb_q;
  assign byp_tx_valid             = tv_q;
  assign byp_tx_take              = tk_q;
endmodule : hsb_device
`default_nettype wire

// ---- logic/hsb_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module hsb_host
  import hsb_pkg::*;
#(
  parameter int unsigned SCK_HALF = SCK_HALF_DEF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  hsb_if.host              lnk
);
  logic [2:0] i1_q, i2_q;
  logic       stb_old_q;
  logic       m1_q, m2_q;
  // strobe idles high, so its synchroniser resets high as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i1_q      <= 3'h4;
      i2_q      <= 3'h4;
      stb_old_q <= 1'b1;
      m1_q      <= 1'b0;
      m2_q      <= 1'b0;
    end else begin
      i1_q      <= {lnk.irq_strobe, lnk.bypass_bit_data_dev, lnk.bypass_bit_valid_dev};
      i2_q      <= i1_q;
      stb_old_q <= i2_q[2];
      m1_q      <= lnk.miso;
      m2_q      <= m1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // registers and engine
  logic       ss_q, ss_d, sck_q, sck_d, mosi_q, mosi_d, busy_q, busy_d;
  logic [7:0] div_q, div_d, tx_q, tx_d, rx_q, rx_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byp_q, byp_d;
  logic [1:0] brx_q, brx_d;
  logic       bv_seen_q, bv_seen_d, htb_q, htb_d, htv_q, htv_d;
  logic       wr_acc;
  always_comb begin
    wr_acc    = psel & penable & pwrite;
    ss_d      = ss_q;
    sck_d     = sck_q;
    mosi_d    = mosi_q;
    busy_d    = busy_q;
    div_d     = div_q;
    tx_d      = tx_q;
    rx_d      = rx_q;
    bit_d     = bit_q;
    byp_d     = byp_q;
    brx_d     = brx_q;
    bv_seen_d = bv_seen_q;
    htb_d     = htb_q;
    htv_d     = htv_q;
    if (wr_acc && paddr == REG_CTRL) begin
      ss_d = ~pwdata[0];
    end
    if (wr_acc && paddr == REG_BYPASS) begin
      byp_d = pwdata[1:0];
      htb_d = pwdata[4];
      htv_d = pwdata[5];
    end
    if (wr_acc && paddr == REG_WDATA && !busy_q && !ss_q) begin
      tx_d   = pwdata[7:0];
      busy_d = 1'b1;
      bit_d  = 4'h0;
      div_d  = 8'h00;
      mosi_d = pwdata[7];
    end else if (busy_q) begin
      if (div_q == 8'(SCK_HALF - 1)) begin
        div_d = 8'h00;
        sck_d = ~sck_q;
        // synced miso still holds the bit that stood at the rising edge
        if (sck_q) begin
          rx_d  = {rx_q[6:0], m2_q};
          tx_d  = {tx_q[6:0], 1'b0};
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            busy_d = 1'b0;
          end else begin
            mosi_d = tx_q[6];
          end
        end
      end else begin
        div_d = div_q + 8'h01;
      end
    end
    if (psel && penable && !pwrite && paddr == REG_STATUS) begin
      bv_seen_d = 1'b0;
    end
    // a new valid bit wins over a clear in the same cycle
    if (i2_q[2] && !stb_old_q) begin
      brx_d     = i2_q[1:0];
      bv_seen_d = bv_seen_d | i2_q[0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_q      <= 1'b1;
      sck_q     <= 1'b0;
      mosi_q    <= 1'b0;
      busy_q    <= 1'b0;
      div_q     <= 8'h00;
      tx_q      <= BYTE_RESET;
      rx_q      <= BYTE_RESET;
      bit_q     <= 4'h0;
      byp_q     <= 2'h0;
      brx_q     <= 2'h0;
      bv_seen_q <= 1'b0;
      htb_q     <= 1'b0;
      htv_q     <= 1'b0;
    end else begin
      ss_q      <= ss_d;
      sck_q     <= sck_d;
      mosi_q    <= mosi_d;
      busy_q    <= busy_d;
      div_q     <= div_d;
      tx_q      <= tx_d;
      rx_q      <= rx_d;
      bit_q     <= bit_d;
      byp_q     <= byp_d;
      brx_q     <= brx_d;
      bv_seen_q <= bv_seen_d;
      htb_q     <= htb_d;
      htv_q     <= htv_d;
    end
  end
  always_comb begin
    unique case (paddr)
      REG_CTRL:   prdata = {31'h0, ~ss_q};
      REG_RDATA:  prdata = {24'h0, rx_q};
      REG_STATUS: prdata = {28'h0, bv_seen_q, brx_q, busy_q};
      REG_BYPASS: prdata = {26'h0, htv_q, htb_q, 2'h0, byp_q};
      default:    prdata = 32'h0;
    endcase
  end
  assign pready                    = 1'b1;
  assign pslverr                   = 1'b0;
  assign lnk.ss_n                  = ss_q;
  assign lnk.sck                   = sck_q;
  assign lnk.mosi                  = mosi_q;
  assign lnk.bypass_bit_data_host  = htb_q;
  assign lnk.bypass_bit_valid_host = htv_q;
  assign lnk.bypass_host_oe        = byp_q[0] & byp_q[1];
endmodule : hsb_host
`default_nettype wire

// ---- testbench/hsb_link_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module hsb_link_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ss_n,
  input wire logic irq_strobe,
  input wire logic bypass_bit_data_dev,
  input wire logic bypass_bit_valid_dev,
  input wire logic bypass_dev_oe,
  input wire logic bypass_host_oe
);
  logic       sck_q;
  logic       sck_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  ////////////////////////////////////////////////////////////////////////////
  // sck rises counted while selected
  always_comb begin
    sck_d = sck;
    bit_cnt_d = bit_cnt_q;
    if (ss_n) begin
      bit_cnt_d = 3'h0;
    end else if (sck && !sck_q) begin
      bit_cnt_d = bit_cnt_q + 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      bit_cnt_q <= 3'h0;
    end else begin
      sck_q <= sck_d;
      bit_cnt_q <= bit_cnt_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence strobe_low_s;
    !irq_strobe [*4];
  endsequence
  sequence strobe_back_s;
    irq_strobe;
  endsequence
  a_sck_idle_low: assert property (ss_n |-> !sck)
    else $error("sck high while deselected");
  a_select_first: assert property ($rose(sck) |-> !ss_n && !$past(ss_n))
    else $error("sck rose without prior select");
  a_mosi_held: assert property (sck && sck_q |-> $stable(mosi))
    else $error("mosi moved while sck high");
  a_miso_held: assert property (sck && sck_q && !ss_n |-> $stable(miso))
    else $error("miso moved while sck high");
  a_byte_whole: assert property ($rose(ss_n) |-> bit_cnt_q == 3'h0)
    else $error("select released mid byte");
  a_strobe_half: assert property ($fell(irq_strobe) |-> strobe_low_s ##1 strobe_back_s)
    else $error("strobe low time wrong");
  a_rx_bit_held: assert property ($rose(irq_strobe) && bypass_dev_oe |->
    $stable(bypass_bit_data_dev) && $stable(bypass_bit_valid_dev))
    else $error("bypass bit moved at strobe rise");
  a_one_driver: assert property (!(bypass_dev_oe && bypass_host_oe))
    else $error("both ends drive bypass");
endmodule : hsb_link_properties
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", nm, e, a); end end
module tb;
  import hsb_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel, penable, pwrite;
  logic [31:0]       paddr, pwdata, prdata;
  logic              pready, pslverr;
  logic              reg_we;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic              byp_enable, byp_tx_mode, byp_rx_bit, byp_rx_valid;
  logic              byp_tx_bit, byp_tx_valid, byp_tx_take;
  logic [7:0]        regs_q [64];
  logic [7:0]        mon_q;
  logic              sck_p;
  int                error_cnt, samples_checked;
  hsb_if lnk_if();
  hsb_device #(.STB_HALF(4)) hsb_device_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk_if.device),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .byp_enable(byp_enable), .byp_tx_mode(byp_tx_mode), .byp_rx_bit(byp_rx_bit),
    .byp_rx_valid(byp_rx_valid), .byp_tx_bit(byp_tx_bit), .byp_tx_valid(byp_tx_valid),
    .byp_tx_take(byp_tx_take));
  hsb_host #(.SCK_HALF(4)) hsb_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk_if.host));
  hsb_link_properties hsb_link_properties_inst (.pclk(pclk), .presetn(presetn), .sck(lnk_if.sck),
    .mosi(lnk_if.mosi), .miso(lnk_if.miso), .ss_n(lnk_if.ss_n), .irq_strobe(lnk_if.irq_strobe),
    .bypass_bit_data_dev(lnk_if.bypass_bit_data_dev), .bypass_bit_valid_dev(lnk_if.bypass_bit_valid_dev),
    .bypass_dev_oe(lnk_if.bypass_dev_oe), .bypass_host_oe(lnk_if.bypass_host_oe));
  ////////////////////////////////////////////////////////////////////////////
  // register file behind the device, mosi monitor
  assign reg_rdata = regs_q[reg_addr];
  always @(posedge pclk) begin
    if (reg_we === 1'b1) regs_q[reg_addr] <= reg_wdata;
    sck_p <= lnk_if.sck;
    if (lnk_if.sck && !sck_p && !lnk_if.ss_n) mon_q <= {mon_q[6:0], lnk_if.mosi};
  end
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin error_cnt++; end_sim(); end
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wait_for(input int what, input int cnt);
    int k, t;
    logic p, s;
    k = 0; t = 0; p = 1'b1;
    while (k < cnt) begin
      @(posedge pclk);
      t++;
      s = (what == 0) ? lnk_if.irq_strobe : (what == 1) ? byp_tx_take : lnk_if.ss_n;
      if (s === 1'b1 && (what != 0 || p !== 1'b1)) k++;
      p = s;
      if (t > 600) begin error_cnt++; end_sim(); end
    end
  endtask : wait_for
  task automatic spi_byte(input logic [7:0] b);
    logic [31:0] r;
    int t;
    apb(1'b1, REG_WDATA, {24'h0, b}, r);
    t = 0;
    do begin apb(1'b0, REG_STATUS, 32'h0, r); t++; end while (r[0] !== 1'b0 && t < 100);
    if (t >= 100) begin error_cnt++; end_sim(); end
  endtask : spi_byte
  task automatic spi_read(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
    logic [31:0] r;
    apb(1'b1, REG_CTRL, 32'h1, r);
    spi_byte(cmd);
    spi_byte(8'h00);
    apb(1'b0, REG_RDATA, 32'h0, r);
    `CHK("rd byte 0", e0, r[7:0])
    spi_byte(8'h00);
    apb(1'b0, REG_RDATA, 32'h0, r);
    `CHK("rd byte 1", e1, r[7:0])
    apb(1'b1, REG_CTRL, 32'h0, r);
    wait_for(2, 1);
  endtask : spi_read
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_write_burst;
    logic [31:0] r;
    apb(1'b1, REG_CTRL, 32'h1, r);
    spi_byte(8'hc5);
    `CHK("mosi cmd", 8'hc5, mon_q)
    spi_byte(8'ha1);
    spi_byte(8'hb2);
    apb(1'b1, REG_CTRL, 32'h0, r);
    wait_for(2, 1);
    repeat (4) @(posedge pclk);
    `CHK("reg 5", 8'ha1, regs_q[5])
    `CHK("reg 6", 8'hb2, regs_q[6])
    `CHK("reg 7", 8'h5d, regs_q[7])
    $display("test_write_burst done");
  endtask : test_write_burst
  task automatic test_read_inc;
    spi_read(8'h45, 8'ha1, 8'hb2);
    $display("test_read_inc done");
  endtask : test_read_inc
  task automatic test_read_fixed;
    spi_read(8'h07, 8'h5d, 8'h5d);
    `CHK("reg 7 kept", 8'h5d, regs_q[7])
    $display("test_read_fixed done");
  endtask : test_read_fixed
  task automatic test_bypass_rx;
    logic [31:0] r;
    byp_enable <= 1'b1; byp_tx_mode <= 1'b0; byp_rx_bit <= 1'b1; byp_rx_valid <= 1'b1;
    wait_for(0, 3);
    apb(1'b0, REG_STATUS, 32'h0, r);
    `CHK("status rx 1", 3'b111, r[3:1])
    byp_rx_bit <= 1'b0;
    wait_for(0, 3);
    apb(1'b0, REG_STATUS, 32'h0, r);
    `CHK("status rx 0", 2'b01, r[2:1])
    $display("test_bypass_rx done");
  endtask : test_bypass_rx
  task automatic test_bypass_tx;
    logic [31:0] r;
    logic [7:0] v;
    byp_tx_mode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'h13 : 8'h23;
      apb(1'b1, REG_BYPASS, {24'h0, v}, r);
      wait_for(1, 2);
      `CHK("tx bit", v[4], byp_tx_bit)
      `CHK("tx valid", v[5], byp_tx_valid)
    end
    $display("test_bypass_tx done");
  endtask : test_bypass_tx
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0; samples_checked = 0; presetn = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    byp_enable = 1'b0; byp_tx_mode = 1'b0; byp_rx_bit = 1'b0; byp_rx_valid = 1'b0;
    for (int i = 0; i < 64; i++) regs_q[i] = 8'(i) ^ 8'h5a;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    test_write_burst();
    test_read_inc();
    test_read_fixed();
    test_bypass_rx();
    test_bypass_tx();
    end_sim();
  end
endmodule : tb
`default_nettype wire
